// ### src/fspm_regs.svh
// register map and constants of the device as seen from the controller
// assumes an 8-bit register port on the device side
`ifndef FSPM_REGS_SVH
`define FSPM_REGS_SVH

`define FSPM_ADDR_INT_MASK      8'h20
`define FSPM_ADDR_FLASH_CMD     8'h21
`define FSPM_ADDR_FLASH_STATUS  8'h22
`define FSPM_ADDR_PROTECT_CMD   8'h23
`define FSPM_ADDR_MODE_CTRL     8'h24
`define FSPM_ADDR_PTR_HIGH      8'h25
`define FSPM_ADDR_PTR_LOW       8'h26
`define FSPM_ADDR_CMP_HIGH      8'h27
`define FSPM_ADDR_CMP_LOW       8'h28
`define FSPM_ADDR_WDT_ENABLE    8'h29

`define FSPM_VAL_ZERO           8'h00
`define FSPM_VAL_ALL_ONES       8'hff
`define FSPM_VAL_UNLOCK_KEY     8'ha5
`define FSPM_VAL_MODE_PROG      8'h01
`define FSPM_VAL_MODE_PROG_INV  8'hfe
`define FSPM_VAL_MODE_NORM      8'h00
`define FSPM_VAL_MODE_NORM_INV  8'hff
`define FSPM_VAL_CMD_ERASE      8'h03
`define FSPM_VAL_WDT_RESTART    8'hac

`define FSPM_BIT_UNLOCK_ERR     0
`define FSPM_BIT_VERIFY_FAIL    1
`define FSPM_BIT_PROTECT_VIOL   2
`define FSPM_RETRY_MAX          4'h3

`endif

// ### src/fspm_pkg.sv
// types shared by the controller modules
package fspm_pkg;
    typedef enum logic [1:0] {
        FSPM_OP_ENTER,
        FSPM_OP_EXIT,
        FSPM_OP_ERASE,
        FSPM_OP_NONE
    } fspm_op_t;

    typedef enum {
        ST_IDLE,
        EN_MRD, EN_MWR, EN_DI,
        U_CMD0, U_SCLR, U_PROT, U_MC1, U_MC2, U_MC3,
        EN_NOP, EN_HALT, U_SRD, EX_MRST,
        ER_CMD, ER_APH, ER_APL, ER_CPH, ER_CPL, ER_SCLR, ER_WDT,
        ER_HALT, ER_SRD,
        ST_RSP
    } fspm_state_t;
endpackage

// ### src/fspm_acc_if.sv
// single register access request between sequencer and port engine
`timescale 1ns/1ns
interface fspm_acc_if;
    logic       req;
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       done;
    logic [7:0] rdata;

    modport seq (output req, wr, addr, wdata, input done, rdata);
    modport eng (input req, wr, addr, wdata, output done, rdata);
endinterface

// ### src/fspm_port.sv
// register port engine: one read or write to the device per request
// assumes the device raises dev_ack once per access, any cycle later
`timescale 1ns/1ns
module fspm_port (
    input  wire logic   clk_sys,
    input  wire logic   rst_n,
    fspm_acc_if.eng     acc,
    output logic        dev_wr_en,
    output logic        dev_rd_en,
    output logic [7:0]  dev_addr,
    output logic [7:0]  dev_wdata,
    input  wire logic [7:0] dev_rdata,
    input  wire logic   dev_ack
);
    logic busy_r;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_r    <= 1'b0;
            dev_wr_en <= 1'b0;
            dev_rd_en <= 1'b0;
            dev_addr  <= 8'h00;
            dev_wdata <= 8'h00;
        end else if (!busy_r && acc.req) begin
            busy_r    <= 1'b1;
            dev_wr_en <= acc.wr;
            dev_rd_en <= !acc.wr;
            dev_addr  <= acc.addr;
            dev_wdata <= acc.wdata;
        end else if (busy_r && dev_ack) begin
            busy_r    <= 1'b0;
            dev_wr_en <= 1'b0;
            dev_rd_en <= 1'b0;
        end
    end

    // done in the ack cycle so the sequencer advances before re-requesting
    assign acc.done  = busy_r && dev_ack;
    assign acc.rdata = dev_rdata;

    property p_no_overlap;
        @(posedge clk_sys) disable iff (!rst_n)
        !(dev_wr_en && dev_rd_en);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("read and write together");
endmodule

// ### src/fspm_ctrl.sv
// controller that moves the device into and out of self-programming mode
// and runs a block erase through the device register port
// assumes device ack on each access and a resume pulse after halt
`timescale 1ns/1ns
`include "fspm_regs.svh"

// Operation
// - program only inside self-programming mode, then leave
// - mask all interrupts and disable before entry
// - clear flash command before each transition
// - clear status before unlock and operation
// - entry key then 01h, feh, 01h
// - nop then halt after entry writes
// - unlock error bit zero retried after status clear
// - exit key then 00h, ffh, 00h
// - raise cpu clock before entering
// - restore clock after clean exit only (clk_boost also drops when entry fails on the last retry)
// - sequence code runs outside erased flash
// - erase command, block pointers, low zeros
// - restart watchdog before starting operation
// - halt starts operation, resume ends it
// - restore interrupts after clean exit
// - block pointer upper nibble kept zero
module fspm_ctrl (
    input  wire logic             clk_sys,
    input  wire logic             rst_n,
    input  wire logic             cmd_valid,
    input  wire fspm_pkg::fspm_op_t cmd_op,
    input  wire logic [3:0]       cmd_block,
    input  wire logic             wdt_used,
    output logic                  cmd_ready,
    output logic                  rsp_valid,
    output logic                  rsp_ok,
    output logic [7:0]            rsp_status,
    output logic                  in_prog_mode,
    output logic                  int_disable,
    output logic                  clk_boost,
    input  wire logic             clk_fast_ok,
    output logic                  dev_halt,
    input  wire logic             dev_resume,
    output logic                  dev_wr_en,
    output logic                  dev_rd_en,
    output logic [7:0]            dev_addr,
    output logic [7:0]            dev_wdata,
    input  wire logic [7:0]       dev_rdata,
    input  wire logic             dev_ack
);
    import fspm_pkg::*;

    fspm_acc_if acc ();

    fspm_state_t state_r;
    fspm_state_t state_nxt;
    logic        to_prog_r;
    logic [3:0]  block_r;
    logic        wdt_r;
    logic [7:0]  mask_save_r;
    logic [3:0]  retry_r;
    logic        is_acc;
    logic        acc_wr;
    logic [7:0]  acc_addr;
    logic [7:0]  acc_data;
    logic [7:0]  mode_val;
    logic [7:0]  mode_inv;
    logic        step;

    fspm_port u_port (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .acc       (acc.eng),
        .dev_wr_en (dev_wr_en),
        .dev_rd_en (dev_rd_en),
        .dev_addr  (dev_addr),
        .dev_wdata (dev_wdata),
        .dev_rdata (dev_rdata),
        .dev_ack   (dev_ack)
    );

    assign mode_val = to_prog_r ? `FSPM_VAL_MODE_PROG : `FSPM_VAL_MODE_NORM;
    assign mode_inv = to_prog_r ? `FSPM_VAL_MODE_PROG_INV
                                : `FSPM_VAL_MODE_NORM_INV;

    // access table: what each state writes or reads
    always_comb begin
        is_acc   = 1'b1;
        acc_wr   = 1'b1;
        acc_addr = 8'h00;
        acc_data = `FSPM_VAL_ZERO;
        case (state_r)
            EN_MRD: begin
                acc_wr   = 1'b0;
                acc_addr = `FSPM_ADDR_INT_MASK;
            end
            EN_MWR: begin
                acc_addr = `FSPM_ADDR_INT_MASK;
                acc_data = `FSPM_VAL_ALL_ONES;
            end
            U_CMD0: acc_addr = `FSPM_ADDR_FLASH_CMD;
            U_SCLR, ER_SCLR: acc_addr = `FSPM_ADDR_FLASH_STATUS;
            U_PROT: begin
                acc_addr = `FSPM_ADDR_PROTECT_CMD;
                acc_data = `FSPM_VAL_UNLOCK_KEY;
            end
            U_MC1, U_MC3: begin
                acc_addr = `FSPM_ADDR_MODE_CTRL;
                acc_data = mode_val;
            end
            U_MC2: begin
                acc_addr = `FSPM_ADDR_MODE_CTRL;
                acc_data = mode_inv;
            end
            U_SRD, ER_SRD: begin
                acc_wr   = 1'b0;
                acc_addr = `FSPM_ADDR_FLASH_STATUS;
            end
            EX_MRST: begin
                acc_addr = `FSPM_ADDR_INT_MASK;
                acc_data = mask_save_r;
            end
            ER_CMD: begin
                acc_addr = `FSPM_ADDR_FLASH_CMD;
                acc_data = `FSPM_VAL_CMD_ERASE;
            end
            ER_APH: begin
                acc_addr = `FSPM_ADDR_PTR_HIGH;
                acc_data = {4'h0, block_r};
            end
            ER_APL: acc_addr = `FSPM_ADDR_PTR_LOW;
            ER_CPH: begin
                acc_addr = `FSPM_ADDR_CMP_HIGH;
                acc_data = {4'h0, block_r};
            end
            ER_CPL: acc_addr = `FSPM_ADDR_CMP_LOW;
            ER_WDT: begin
                acc_addr = `FSPM_ADDR_WDT_ENABLE;
                acc_data = `FSPM_VAL_WDT_RESTART;
            end
            default: is_acc = 1'b0;
        endcase
    end

    assign acc.req   = is_acc;
    assign acc.wr    = acc_wr;
    assign acc.addr  = acc_addr;
    assign acc.wdata = acc_data;
    assign step      = is_acc && acc.done;
    assign cmd_ready = (state_r == ST_IDLE);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (cmd_valid) begin
                    case (cmd_op)
                        FSPM_OP_ENTER: state_nxt = in_prog_mode ? ST_RSP
                                                                : EN_MRD;
                        FSPM_OP_EXIT:  state_nxt = in_prog_mode ? U_CMD0
                                                                : ST_RSP;
                        // no erase while in normal mode
                        FSPM_OP_ERASE: state_nxt = in_prog_mode ? ER_CMD
                                                                : ST_RSP;
                        default:       state_nxt = ST_RSP;
                    endcase
                end
            end
            EN_MRD:  if (step) state_nxt = EN_MWR;
            EN_MWR:  if (step) state_nxt = EN_DI;
            EN_DI:   if (clk_fast_ok) state_nxt = U_CMD0;
            U_CMD0:  if (step) state_nxt = U_SCLR;
            U_SCLR:  if (step) state_nxt = U_PROT;
            U_PROT:  if (step) state_nxt = U_MC1;
            U_MC1:   if (step) state_nxt = U_MC2;
            U_MC2:   if (step) state_nxt = U_MC3;
            U_MC3:   if (step) state_nxt = to_prog_r ? EN_NOP : U_SRD;
            EN_NOP:  state_nxt = EN_HALT;
            EN_HALT: if (dev_resume) state_nxt = U_SRD;
            U_SRD: begin
                if (step) begin
                    if (acc.rdata[`FSPM_BIT_UNLOCK_ERR])
                        state_nxt = (retry_r == `FSPM_RETRY_MAX) ? ST_RSP
                                                                 : U_SCLR;
                    else
                        state_nxt = to_prog_r ? ST_RSP : EX_MRST;
                end
            end
            EX_MRST: if (step) state_nxt = ST_RSP;
            ER_CMD:  if (step) state_nxt = ER_APH;
            ER_APH:  if (step) state_nxt = ER_APL;
            ER_APL:  if (step) state_nxt = ER_CPH;
            ER_CPH:  if (step) state_nxt = ER_CPL;
            ER_CPL:  if (step) state_nxt = ER_SCLR;
            ER_SCLR: if (step) state_nxt = wdt_r ? ER_WDT : ER_HALT;
            ER_WDT:  if (step) state_nxt = ER_HALT;
            ER_HALT: if (dev_resume) state_nxt = ER_SRD;
            ER_SRD:  if (step) state_nxt = ST_RSP;
            ST_RSP:  state_nxt = ST_IDLE;
            default: state_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            state_r <= ST_IDLE;
        else
            state_r <= state_nxt;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            to_prog_r <= 1'b0;
            block_r   <= 4'h0;
            wdt_r     <= 1'b0;
        end else if (state_r == ST_IDLE && cmd_valid) begin
            to_prog_r <= (cmd_op == FSPM_OP_ENTER);
            block_r   <= cmd_block;
            wdt_r     <= wdt_used;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            mask_save_r <= 8'h00;
        else if (state_r == EN_MRD && step)
            mask_save_r <= acc.rdata;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            retry_r <= 4'h0;
        else if (state_r == ST_IDLE)
            retry_r <= 4'h0;
        else if (state_r == U_SRD && step)
            retry_r <= retry_r + 4'h1;
    end

    // interrupt disable and clock boost span the whole programming window
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            int_disable  <= 1'b0;
            clk_boost    <= 1'b0;
            in_prog_mode <= 1'b0;
        end else if (state_r == EN_MWR && step) begin
            int_disable <= 1'b1;
            clk_boost   <= 1'b1;
        end else if (state_r == U_SRD && step) begin
            if (!acc.rdata[`FSPM_BIT_UNLOCK_ERR])
                in_prog_mode <= to_prog_r;
            else if (to_prog_r && retry_r == `FSPM_RETRY_MAX) begin
                int_disable <= 1'b0;
                clk_boost   <= 1'b0;
            end
        end else if (state_r == EX_MRST && step) begin
            int_disable <= 1'b0;
            clk_boost   <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
            dev_halt <= 1'b0;
        else if (state_nxt == EN_HALT || state_nxt == ER_HALT)
            dev_halt <= 1'b1;
        else
            dev_halt <= 1'b0;
    end

    // results: status byte kept, ok flag per kind of operation
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rsp_valid  <= 1'b0;
            rsp_ok     <= 1'b0;
            rsp_status <= 8'h00;
        end else begin
            rsp_valid <= (state_nxt == ST_RSP);
            if (state_r == ST_IDLE && cmd_valid)
                rsp_ok <= 1'b0;
            else if (state_r == U_SRD && step) begin
                rsp_status <= acc.rdata;
                rsp_ok     <= !acc.rdata[`FSPM_BIT_UNLOCK_ERR];
            end else if (state_r == ER_SRD && step) begin
                rsp_status <= acc.rdata;
                rsp_ok     <= !acc.rdata[`FSPM_BIT_VERIFY_FAIL] &&
                              !acc.rdata[`FSPM_BIT_PROTECT_VIOL];
            end
        end
    end

    property p_erase_halt_mode;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ER_HALT) |-> in_prog_mode;
    endproperty
    a_erase_halt_mode: assert property (p_erase_halt_mode)
        else $error("erase halt outside programming mode");

    property p_key_irq_off;
        @(posedge clk_sys) disable iff (!rst_n)
        (dev_wr_en && dev_addr == `FSPM_ADDR_PROTECT_CMD) |->
            int_disable && clk_boost;
    endproperty
    a_key_irq_off: assert property (p_key_irq_off)
        else $error("unlock key with interrupts or slow clock");

    property p_key_after_clear;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == U_PROT && $past(state_r) != U_PROT) |->
            $past(state_r) == U_SCLR;
    endproperty
    a_key_after_clear: assert property (p_key_after_clear)
        else $error("unlock key without status clear");

    property p_mode_triple;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == U_PROT && step) |=> (state_r == U_MC1) [*1] ##0
            (acc_data == mode_val);
    endproperty
    a_mode_triple: assert property (p_mode_triple)
        else $error("first mode write wrong");

    property p_exit_values;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == U_MC2 && !to_prog_r) |->
            acc_data == `FSPM_VAL_MODE_NORM_INV;
    endproperty
    a_exit_values: assert property (p_exit_values)
        else $error("exit complement wrong");

    property p_nop_halt;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == EN_NOP) |=> dev_halt ##0 (state_r == EN_HALT);
    endproperty
    a_nop_halt: assert property (p_nop_halt)
        else $error("no halt after nop");

    property p_halt_hold;
        @(posedge clk_sys) disable iff (!rst_n)
        (dev_halt && !dev_resume) |=> dev_halt;
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("halt dropped before resume");

    property p_clock_restore;
        @(posedge clk_sys) disable iff (!rst_n)
        $fell(clk_boost) |-> !in_prog_mode;
    endproperty
    a_clock_restore: assert property (p_clock_restore)
        else $error("clock restored while in programming mode");

    property p_erase_block;
        @(posedge clk_sys) disable iff (!rst_n)
        (dev_wr_en && dev_addr == `FSPM_ADDR_CMP_HIGH && in_prog_mode) |->
            dev_wdata[7:4] == 4'h0;
    endproperty
    a_erase_block: assert property (p_erase_block)
        else $error("compare high upper nibble set");

    property p_erase_ok;
        @(posedge clk_sys) disable iff (!rst_n)
        (state_r == ER_SRD && step) |=>
            rsp_ok == (rsp_status[2:1] == 2'b00) ##0 rsp_valid;
    endproperty
    a_erase_ok: assert property (p_erase_ok)
        else $error("erase result flag wrong");

    c_enter: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(in_prog_mode));
    c_retry: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == U_SRD && step && acc.rdata[0] ##1 state_r == U_SCLR);
    c_erase: cover property (@(posedge clk_sys) disable iff (!rst_n)
        state_r == ER_SRD && step);
    c_exit: cover property (@(posedge clk_sys) disable iff (!rst_n)
        $fell(in_prog_mode));
endmodule

// ### testbench/fspm_dev_model.sv
// device-side model: register port, unlock sequencer, halt-run erase
// assumes one access at a time, strobes held until the ack edge
`timescale 1ns/1ns
module fspm_dev_model #(
    parameter logic [7:0] MASK_INIT = 8'h3c,
    parameter int         HALT_CYC  = 6
) (
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       dev_wr_en,
    input  wire logic       dev_rd_en,
    input  wire logic [7:0] dev_addr,
    input  wire logic [7:0] dev_wdata,
    output logic [7:0]      dev_rdata,
    output logic            dev_ack,
    input  wire logic       dev_halt,
    output logic            dev_resume,
    input  wire logic [3:0] ack_wait,
    input  wire logic       unlock_bad,
    input  wire logic       verify_bad,
    input  wire logic [3:0] prot_below,
    output logic            prog_mode,
    output int              erase_cnt
);
    logic [7:0] regs_r [0:15];
    logic [3:0] cnt_r;
    logic [1:0] step_r;
    logic       armed_r;
    logic [7:0] first_r;
    logic       halt_d_r;
    int         busy_r;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < 16; i++) regs_r[i] <= 8'h00;
            regs_r[0] <= MASK_INIT;
            {dev_ack, dev_resume, prog_mode, armed_r, halt_d_r} <= 5'h00;
            {cnt_r, step_r, first_r, dev_rdata} <= 22'h0;
            busy_r <= 0;
            erase_cnt <= 0;
        end else begin
            dev_resume <= 1'b0;
            halt_d_r <= dev_halt;
            if (dev_ack) begin
                dev_ack <= 1'b0;
                cnt_r <= 4'h0;
                // released bus shows no stale byte
                dev_rdata <= ~dev_rdata;
            end else if ((dev_wr_en || dev_rd_en) && cnt_r != ack_wait) begin
                cnt_r <= cnt_r + 4'h1;
            end else if (dev_rd_en) begin
                dev_ack <= 1'b1;
                dev_rdata <= regs_r[dev_addr[3:0]];
            end else if (dev_wr_en) begin
                dev_ack <= 1'b1;
                if (dev_addr == 8'h23) begin
                    armed_r <= (dev_wdata == 8'ha5);
                    step_r <= 2'h0;
                end else if (dev_addr != 8'h24) begin
                    regs_r[dev_addr[3:0]] <= dev_wdata;
                end else if (armed_r && step_r == 2'h0) begin
                    first_r <= dev_wdata;
                    step_r <= 2'h1;
                end else if (armed_r && step_r == 2'h1
                             && dev_wdata == ~first_r) begin
                    step_r <= 2'h2;
                end else if (armed_r && step_r == 2'h2 && !unlock_bad
                             && dev_wdata == first_r
                             && dev_wdata[7:1] == 7'h00) begin
                    prog_mode <= dev_wdata[0];
                    armed_r <= 1'b0;
                end else begin
                    regs_r[2][0] <= 1'b1;
                    armed_r <= 1'b0;
                end
            end
            if (dev_halt && !halt_d_r) begin
                busy_r <= HALT_CYC;
                if (prog_mode && regs_r[1] == 8'h03) begin
                    if (regs_r[5][3:0] < prot_below) regs_r[2][2] <= 1'b1;
                    else begin
                        erase_cnt <= erase_cnt + 1;
                        if (verify_bad) regs_r[2][1] <= 1'b1;
                    end
                end
            end else if (busy_r > 0) begin
                busy_r <= busy_r - 1;
                dev_resume <= (busy_r == 1);
            end
        end
    end
endmodule

// ### testbench/fspm_ctrl_tb.sv
// self-checking bench for the self-programming mode controller
// assumes the device model answers every access and every halt
`timescale 1ns/1ns
`define CHK(g, e) begin \
    compares++; \
    if ((g) !== (e)) begin \
        err_total++; \
        $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); \
    end \
end
module fspm_ctrl_tb;
    import fspm_pkg::*;
    logic       clk_sys, rst_n, cmd_valid, wdt_used, cmd_ready;
    logic       rsp_valid, rsp_ok, in_prog_mode, int_disable, clk_boost;
    logic       clk_fast_ok, dev_halt, dev_resume, dev_wr_en, dev_rd_en;
    logic       dev_ack, unlock_bad, verify_bad, prog_mode;
    logic [3:0] cmd_block, ack_wait, prot_below;
    logic [7:0] rsp_status, dev_addr, dev_wdata, dev_rdata;
    fspm_op_t   cmd_op;
    logic [15:0] wr_q[$];
    logic [15:0] exp_q[$];
    int         err_total, compares, erase_cnt;

    fspm_ctrl fspm_ctrl_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_block(cmd_block),
        .wdt_used(wdt_used), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
        .rsp_ok(rsp_ok), .rsp_status(rsp_status),
        .in_prog_mode(in_prog_mode), .int_disable(int_disable),
        .clk_boost(clk_boost), .clk_fast_ok(clk_fast_ok),
        .dev_halt(dev_halt), .dev_resume(dev_resume),
        .dev_wr_en(dev_wr_en), .dev_rd_en(dev_rd_en), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack));

    fspm_dev_model fspm_dev_model_i (.clk_sys(clk_sys), .rst_n(rst_n),
        .dev_wr_en(dev_wr_en), .dev_rd_en(dev_rd_en), .dev_addr(dev_addr),
        .dev_wdata(dev_wdata), .dev_rdata(dev_rdata), .dev_ack(dev_ack),
        .dev_halt(dev_halt), .dev_resume(dev_resume), .ack_wait(ack_wait),
        .unlock_bad(unlock_bad), .verify_bad(verify_bad),
        .prot_below(prot_below), .prog_mode(prog_mode),
        .erase_cnt(erase_cnt));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    // log of completed writes as {address, data}
    // sampled mid-cycle: the ack cycle is settled there, no edge race
    always @(negedge clk_sys) begin
        if (dev_wr_en === 1'b1 && dev_ack === 1'b1)
            wr_q.push_back({dev_addr, dev_wdata});
    end

    task automatic summarize;
        $display("compares=%0d err_total=%0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic run(input fspm_op_t op, input logic [3:0] blk,
                       input logic w);
        int n;
        wr_q.delete();
        @(posedge clk_sys);
        #10;
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_block = blk;
        wdt_used = w;
        @(posedge clk_sys);
        #10;
        cmd_valid = 1'b0;
        // a refused command answers in the cycle right after it is taken
        for (n = 0; n < 3000; n++) begin
            if (rsp_valid === 1'b1) break;
            @(posedge clk_sys);
            #1;
        end
        if (n == 3000) begin
            err_total++;
            summarize;
        end
    endtask

    task automatic chk_log;
        `CHK(wr_q.size(), exp_q.size())
        foreach (exp_q[i]) `CHK(wr_q[i], exp_q[i])
    endtask

    task automatic s_reset;
        `CHK({cmd_ready, rsp_valid, in_prog_mode, int_disable}, 4'h8)
        `CHK({clk_boost, dev_halt, dev_wr_en, dev_rd_en}, 4'h0)
    endtask

    task automatic s_refuse;
        run(FSPM_OP_ERASE, 4'h3, 1'b1);
        `CHK(rsp_ok, 1'b0)
        `CHK(wr_q.size(), 0)
        `CHK(erase_cnt, 0)
        run(FSPM_OP_EXIT, 4'h0, 1'b0);
        `CHK(rsp_ok, 1'b0)
    endtask

    task automatic s_enter;
        ack_wait = 4'h4;
        clk_fast_ok = 1'b0;
        fork
            begin
                repeat (80) @(posedge clk_sys);
                #10;
                `CHK(wr_q.size(), 1)
                `CHK(clk_boost, 1'b1)
                clk_fast_ok = 1'b1;
            end
        join_none
        run(FSPM_OP_ENTER, 4'h0, 1'b0);
        exp_q = '{16'h20ff, 16'h2100, 16'h2200, 16'h23a5, 16'h2401,
                  16'h24fe, 16'h2401};
        chk_log;
        `CHK({rsp_ok, in_prog_mode, prog_mode}, 3'b111)
        `CHK(int_disable, 1'b1)
        run(FSPM_OP_ENTER, 4'h0, 1'b0);
        `CHK(rsp_ok, 1'b0)
    endtask

    task automatic s_erase_ok;
        ack_wait = 4'h0;
        run(FSPM_OP_ERASE, 4'h5, 1'b1);
        exp_q = '{16'h2103, 16'h2505, 16'h2600, 16'h2705, 16'h2800,
                  16'h2200, 16'h29ac};
        chk_log;
        `CHK({rsp_ok, rsp_status}, 9'h100)
        `CHK(erase_cnt, 1)
    endtask

    task automatic s_erase_prot;
        prot_below = 4'h2;
        run(FSPM_OP_ERASE, 4'h1, 1'b0);
        exp_q = '{16'h2103, 16'h2501, 16'h2600, 16'h2701, 16'h2800,
                  16'h2200};
        chk_log;
        `CHK({rsp_ok, rsp_status}, 9'h004)
        `CHK(erase_cnt, 1)
    endtask

    task automatic s_erase_vfy;
        verify_bad = 1'b1;
        run(FSPM_OP_ERASE, 4'h2, 1'b1);
        `CHK({rsp_ok, rsp_status}, 9'h002)
        `CHK(erase_cnt, 2)
        verify_bad = 1'b0;
    endtask

    task automatic s_exit;
        run(FSPM_OP_EXIT, 4'h0, 1'b0);
        exp_q = '{16'h2100, 16'h2200, 16'h23a5, 16'h2400, 16'h24ff,
                  16'h2400, 16'h203c};
        chk_log;
        `CHK({rsp_ok, prog_mode, in_prog_mode}, 3'b100)
        `CHK({int_disable, clk_boost}, 2'b00)
    endtask

    task automatic s_enter_fail;
        int n;
        n = 0;
        unlock_bad = 1'b1;
        run(FSPM_OP_ENTER, 4'h0, 1'b0);
        foreach (wr_q[i]) if (wr_q[i] === 16'h23a5) n++;
        `CHK(n, 4)
        `CHK({rsp_ok, prog_mode, in_prog_mode}, 3'b000)
        `CHK({int_disable, clk_boost}, 2'b00)
    endtask

    initial begin
        {rst_n, cmd_valid, wdt_used, unlock_bad, verify_bad} = 5'h00;
        cmd_op = FSPM_OP_NONE;
        {cmd_block, ack_wait, prot_below} = 12'h000;
        clk_fast_ok = 1'b1;
        err_total = 0;
        compares = 0;
        repeat (8) @(posedge clk_sys);
        #10;
        s_reset;
        rst_n = 1'b1;
        s_refuse;
        s_enter;
        s_erase_ok;
        s_erase_prot;
        s_erase_vfy;
        s_exit;
        s_enter_fail;
        summarize;
    end
endmodule
